/* design/dspm_pkg.sv */
package dspm_pkg;
    localparam int NPIN      = 66;
    localparam int NMSET     = 9;
    localparam int MSET_PINS = 8;
    localparam int NCSET     = 3;
    localparam int CSET_PINS = 32;
    localparam int MPRI      = 11;
    localparam int MALT      = 4;
    localparam int MSLOT     = MPRI + MALT;
    localparam int CSIG      = 4;
    localparam int NTRIP     = 12;
    localparam int NCAP      = 6;
    localparam int NXINT     = 3;
    localparam int NROUTE    = NTRIP + NCAP + NXINT + 1;
    localparam int ROUTE_CAP = NTRIP;
    localparam int ROUTE_XI  = NTRIP + NCAP;
    localparam int ROUTE_WK  = NTRIP + NCAP + NXINT;
    localparam int SELW      = 6;
    localparam int NLPM      = 64;
    localparam int XPIN_A    = 39;
    localparam int XPIN_B    = 44;
    localparam int CLK_PIN   = 63;
    localparam int NUSB      = 4;
    localparam int USB_PIN [NUSB] = '{38, 42, 45, 46};
    localparam logic [3:0] PCTL_GPIO = 4'h0;

    // one master-side pin field: function code, alternate path, own gpio
    typedef struct packed {
        logic [3:0] port_function_select;
        logic       alternate_path_select;
        logic       gpio_oe;
        logic       gpio_out;
        logic       irq_en;
    } dspm_mcfg_t;

    // one control-side pin field: ownership, 4-way mux, own gpio
    typedef struct packed {
        logic       own;
        logic [1:0] mux;
        logic       gpio_sel;
        logic       gpio_oe;
        logic       gpio_out;
    } dspm_ccfg_t;

    typedef struct packed {
        logic [MSLOT-1:0] o;
        logic [MSLOT-1:0] oe;
    } dspm_mper_t;

    typedef struct packed {
        logic [CSIG-1:0] o;
        logic [CSIG-1:0] oe;
    } dspm_cper_t;

    typedef struct packed {
        logic [NPIN-1:0]            sync1;
        logic [NPIN-1:0]            sync2;
        logic [NPIN-1:0]            pad_out;
        logic [NPIN-1:0]            pad_oe;
        logic [NPIN-1:0]            pad_pu;
        logic [NPIN-1:0]            m_gpio_in;
        logic [NPIN-1:0]            c_gpi;
        logic [NPIN-1:0][MSLOT-1:0] m_in;
        logic [NPIN-1:0][CSIG-1:0]  c_in;
        logic [NMSET-1:0]           irq;
        logic [NROUTE-1:0]          route;
        logic [NUSB-1:0]            usb_an;
        logic                       clk_usb;
        logic [1:0]                 clk_can;
    } dspm_state_t;
endpackage : dspm_pkg

/* design/dspm_pin_mux.sv */
`timescale 1ns/1ps
module dspm_pin_mux
    import dspm_pkg::*;
(
    input  wire logic                                          I_CLK,
    input  wire logic                                          I_RST,
    input  wire logic [dspm_pkg::NPIN-1:0]                     I_PAD_IN,
    input  wire dspm_pkg::dspm_mcfg_t [dspm_pkg::NMSET-1:0][dspm_pkg::MSET_PINS-1:0] I_M_CFG,
    input  wire dspm_pkg::dspm_ccfg_t [dspm_pkg::NCSET-1:0][dspm_pkg::CSET_PINS-1:0] I_C_CFG,
    input  wire logic [dspm_pkg::NPIN-1:0]                     I_PULLUP_EN,
    input  wire logic [dspm_pkg::NUSB-1:0]                     I_ANALOG_MODE_SELECT,
    input  wire logic [dspm_pkg::NROUTE-1:0][dspm_pkg::SELW-1:0] I_ROUTE_SEL,
    input  wire dspm_pkg::dspm_mper_t [dspm_pkg::NPIN-1:0]     I_M_PERIPH,
    input  wire dspm_pkg::dspm_cper_t [dspm_pkg::NPIN-1:0]     I_C_PERIPH,
    output logic [dspm_pkg::NPIN-1:0]                          O_PAD_OUT,
    output logic [dspm_pkg::NPIN-1:0]                          O_PAD_OE,
    output logic [dspm_pkg::NPIN-1:0]                          O_PAD_PULLUP,
    output logic [dspm_pkg::NPIN-1:0][dspm_pkg::MSLOT-1:0]     O_M_PERIPH_IN,
    output logic [dspm_pkg::NPIN-1:0][dspm_pkg::CSIG-1:0]      O_C_PERIPH_IN,
    output logic [dspm_pkg::NPIN-1:0]                          O_M_GPIO_IN,
    output logic [dspm_pkg::NMSET-1:0]                         O_M_IRQ,
    output logic [dspm_pkg::NTRIP-1:0]                         O_PIN_TRIP_EVENTS,
    output logic [dspm_pkg::NCAP-1:0]                          O_CAPTURE_IN,
    output logic [dspm_pkg::NXINT-1:0]                         O_CTRL_XINT,
    output logic                                               O_STANDBY_WAKE_SIGNAL,
    output logic [dspm_pkg::NLPM-1:0]                          O_CONTROL_SIDE_PIN_INPUTS,
    output logic [dspm_pkg::NPIN-1:0]                          O_QUAL_PIN_INPUTS,
    output logic [dspm_pkg::NUSB-1:0]                          O_USB_ANALOG_EN,
    output logic                                               O_USB_PLL_REF_CLOCK,
    output logic [1:0]                                         O_CAN_AUX_CLOCK
);
    import dspm_pkg::*;

    dspm_state_t s_r;
    dspm_state_t s_nxt;

    always_comb
    begin
        logic [NPIN-1:0] an;
        logic [NPIN-1:0] dig;
        logic [NPIN-1:0] irq_src;
        dspm_mcfg_t      mc;
        dspm_ccfg_t      cc;
        logic            m_out;
        logic            m_oe;
        logic            m_valid;
        logic            c_out;
        logic            c_oe;
        int              slot;
        int              sel;
        an      = '0;
        dig     = '0;
        irq_src = '0;
        mc      = '0;
        cc      = '0;
        m_out   = 1'b0;
        m_oe    = 1'b0;
        m_valid = 1'b0;
        c_out   = 1'b0;
        c_oe    = 1'b0;
        slot    = 0;
        sel     = 0;
        s_nxt   = s_r;
        // two stages before anything looks at a pad
        s_nxt.sync1 = I_PAD_IN;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.m_in  = '0;
        s_nxt.c_in  = '0;
        for (int u = 0; u < NUSB; u++)
        begin
            an[USB_PIN[u]] = I_ANALOG_MODE_SELECT[u];
        end
        s_nxt.usb_an = I_ANALOG_MODE_SELECT;
        for (int p = 0; p < NPIN; p++)
        begin
            mc = I_M_CFG[p / MSET_PINS][p % MSET_PINS];
            cc = I_C_CFG[p / CSET_PINS][p % CSET_PINS];
            dig[p] = s_r.sync2[p] & ~an[p];
            // master path: function field picks the candidate slot
            m_valid = 1'b0;
            slot = 0;
            if (mc.port_function_select == PCTL_GPIO)
            begin
                m_out = mc.gpio_out;
                m_oe  = mc.gpio_oe;
            end
            else
            begin
                if (mc.alternate_path_select)
                begin
                    slot = MPRI + int'(mc.port_function_select[1:0]);
                    m_valid = 1'b1;
                end
                else if (int'(mc.port_function_select) <= MPRI)
                begin
                    slot = int'(mc.port_function_select) - 1;
                    m_valid = 1'b1;
                end
                // out-of-range code selects nothing and leaves the pin floating
                m_out = m_valid & I_M_PERIPH[p].o[slot];
                m_oe  = m_valid & I_M_PERIPH[p].oe[slot];
            end
            // control path
            if (cc.gpio_sel)
            begin
                c_out = cc.gpio_out;
                c_oe  = cc.gpio_oe;
            end
            else
            begin
                c_out = I_C_PERIPH[p].o[cc.mux];
                c_oe  = I_C_PERIPH[p].oe[cc.mux];
            end
            // pin-level selector
            if (an[p])
            begin
                s_nxt.pad_out[p] = 1'b0;
                s_nxt.pad_oe[p]  = 1'b0;
            end
            else if (cc.own)
            begin
                s_nxt.pad_out[p] = c_out;
                s_nxt.pad_oe[p]  = c_oe;
                if (!cc.gpio_sel)
                begin
                    s_nxt.c_in[p][cc.mux] = dig[p];
                end
            end
            else
            begin
                s_nxt.pad_out[p] = m_out;
                s_nxt.pad_oe[p]  = m_oe;
                if (m_valid)
                begin
                    s_nxt.m_in[p][slot] = dig[p];
                end
            end
            s_nxt.pad_pu[p] = I_PULLUP_EN[p];
            irq_src[p] = dig[p] & mc.irq_en;
        end
        s_nxt.m_gpio_in = dig;
        s_nxt.c_gpi     = dig;
        for (int k = 0; k < NMSET; k++)
        begin
            s_nxt.irq[k] = 1'b0;
            for (int j = 0; j < MSET_PINS; j++)
            begin
                if (k * MSET_PINS + j < NPIN)
                begin
                    s_nxt.irq[k] = s_nxt.irq[k] | irq_src[k * MSET_PINS + j];
                end
            end
        end
        // pins 39 and 44 have no path into the routed inputs
        for (int r = 0; r < NROUTE; r++)
        begin
            sel = int'(I_ROUTE_SEL[r]);
            s_nxt.route[r] = (sel != XPIN_A) && (sel != XPIN_B) && dig[sel];
        end
        // the clock pin bypasses mux and analog settings; registered, so this
        // path only suits clocks well below the system clock
        s_nxt.clk_usb = s_r.sync2[CLK_PIN];
        s_nxt.clk_can = {2{s_r.sync2[CLK_PIN]}};
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign O_PAD_OUT                 = s_r.pad_out;
    assign O_PAD_OE                  = s_r.pad_oe;
    assign O_PAD_PULLUP              = s_r.pad_pu;
    assign O_M_PERIPH_IN             = s_r.m_in;
    assign O_C_PERIPH_IN             = s_r.c_in;
    assign O_M_GPIO_IN               = s_r.m_gpio_in;
    assign O_M_IRQ                   = s_r.irq;
    assign O_PIN_TRIP_EVENTS         = s_r.route[NTRIP-1:0];
    assign O_CAPTURE_IN              = s_r.route[ROUTE_XI-1:ROUTE_CAP];
    assign O_CTRL_XINT               = s_r.route[ROUTE_WK-1:ROUTE_XI];
    assign O_STANDBY_WAKE_SIGNAL     = s_r.route[ROUTE_WK];
    assign O_CONTROL_SIDE_PIN_INPUTS = s_r.c_gpi[NLPM-1:0];
    assign O_QUAL_PIN_INPUTS         = s_r.c_gpi;
    assign O_USB_ANALOG_EN           = s_r.usb_an;
    assign O_USB_PLL_REF_CLOCK       = s_r.clk_usb;
    assign O_CAN_AUX_CLOCK           = s_r.clk_can;

    a_reset_all_off: assert property (@(posedge I_CLK) I_RST |=>
        (O_PAD_OE == '0) && (O_PAD_PULLUP == '0) && (O_C_PERIPH_IN == '0))
        else $error("pads not quiet after reset");

    a_pullup_each_pin: assert property (@(posedge I_CLK) disable iff (I_RST)
        !$rose(I_RST) |=> O_PAD_PULLUP == $past(I_PULLUP_EN))
        else $error("pullup does not follow its enable");

    a_owner_ctrl_blocks: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_C_CFG[0][20].own |=> O_M_PERIPH_IN[20] == '0)
        else $error("master peripheral sees a control-owned pin");

    a_irq_set_two: assert property (@(posedge I_CLK) disable iff (I_RST)
        ##1 O_M_IRQ[2] == |($past(s_r.sync2[23:16])
            & {$past(I_M_CFG[2][7].irq_en), $past(I_M_CFG[2][6].irq_en),
               $past(I_M_CFG[2][5].irq_en), $past(I_M_CFG[2][4].irq_en),
               $past(I_M_CFG[2][3].irq_en), $past(I_M_CFG[2][2].irq_en),
               $past(I_M_CFG[2][1].irq_en), $past(I_M_CFG[2][0].irq_en)}))
        else $error("set two interrupt mismatch");

    a_trip_excluded_pin: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_ROUTE_SEL[0] == 6'h27 || I_ROUTE_SEL[0] == 6'h2C) |=> !O_PIN_TRIP_EVENTS[0])
        else $error("excluded pin reached a trip input");

    a_lpm_inputs_pass: assert property (@(posedge I_CLK) disable iff (I_RST)
        ##1 O_CONTROL_SIDE_PIN_INPUTS[7:0] == $past(s_r.sync2[7:0]))
        else $error("wake selection inputs differ from pins");

    a_analog_pin_off: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ANALOG_MODE_SELECT[1] |=> !O_PAD_OE[42] && !O_QUAL_PIN_INPUTS[42])
        else $error("analog pin still digital");

    a_ext_clock_tied: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(I_PAD_IN[CLK_PIN]) ##1 I_PAD_IN[CLK_PIN] ##1 I_PAD_IN[CLK_PIN]
        |=> O_USB_PLL_REF_CLOCK && (O_CAN_AUX_CLOCK == 2'h3))
        else $error("aux clock not forwarded in three cycles");

    a_idle_pin_hiz: assert property (@(posedge I_CLK) disable iff (I_RST)
        (!I_C_CFG[0][5].own && ((I_M_CFG[0][5].port_function_select == 4'h0
            && !I_M_CFG[0][5].gpio_oe) || (I_M_CFG[0][5].port_function_select > 4'hB
            && !I_M_CFG[0][5].alternate_path_select))) |=> !O_PAD_OE[5])
        else $error("unassigned pin drives");

    a_reset_quiet_out: assert property (@(posedge I_CLK) I_RST |=>
        (O_PAD_OUT == '0) && (O_M_PERIPH_IN == '0) && (O_M_IRQ == '0))
        else $error("outputs not cleared by reset");

    a_master_gpio_drive: assert property (@(posedge I_CLK) disable iff (I_RST)
        (!I_C_CFG[0][5].own && I_M_CFG[0][5].port_function_select == 4'h0) |=>
        O_PAD_OE[5] == $past(I_M_CFG[0][5].gpio_oe)
        && O_PAD_OUT[5] == $past(I_M_CFG[0][5].gpio_out))
        else $error("master gpio does not reach its pad");

    a_ctrl_gpio_drive: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_C_CFG[0][20].own && I_C_CFG[0][20].gpio_sel) |=>
        O_PAD_OE[20] == $past(I_C_CFG[0][20].gpio_oe)
        && O_PAD_OUT[20] == $past(I_C_CFG[0][20].gpio_out))
        else $error("control gpio does not reach its pad");

    a_master_gpio_in: assert property (@(posedge I_CLK) disable iff (I_RST)
        ##1 O_M_GPIO_IN[21:0] == $past(s_r.sync2[21:0]))
        else $error("master gpio input differs from pins");

    a_route_trip_pass: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ROUTE_SEL[5] == 6'h05 |=> O_PIN_TRIP_EVENTS[5] == $past(s_r.sync2[5]))
        else $error("trip input does not follow its pin");

    a_cap_excluded: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_ROUTE_SEL[ROUTE_CAP] == 6'h27 || I_ROUTE_SEL[ROUTE_CAP] == 6'h2C)
        |=> !O_CAPTURE_IN[0])
        else $error("excluded pin reached a capture input");

    a_xint_excluded: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_ROUTE_SEL[ROUTE_XI] == 6'h27 || I_ROUTE_SEL[ROUTE_XI] == 6'h2C)
        |=> !O_CTRL_XINT[0])
        else $error("excluded pin reached an external interrupt");

    a_wake_excluded: assert property (@(posedge I_CLK) disable iff (I_RST)
        (I_ROUTE_SEL[ROUTE_WK] == 6'h27 || I_ROUTE_SEL[ROUTE_WK] == 6'h2C)
        |=> !O_STANDBY_WAKE_SIGNAL)
        else $error("excluded pin reached the wake signal");

    a_qual_top_pins: assert property (@(posedge I_CLK) disable iff (I_RST)
        ##1 O_QUAL_PIN_INPUTS[65:64] == $past(s_r.sync2[65:64]))
        else $error("top pins missing from qualification");

    a_analog_en_copy: assert property (@(posedge I_CLK) disable iff (I_RST)
        ##1 O_USB_ANALOG_EN == $past(I_ANALOG_MODE_SELECT))
        else $error("usb analog enable does not follow select");

    a_analog_no_return: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ANALOG_MODE_SELECT[0] |=> (O_M_PERIPH_IN[38] == '0)
        && (O_C_PERIPH_IN[38] == '0) && !O_M_GPIO_IN[38])
        else $error("analog pin still returns digital input");

    a_analog_no_drive: assert property (@(posedge I_CLK) disable iff (I_RST)
        I_ANALOG_MODE_SELECT[3] |=> !O_PAD_OE[46] && !O_PAD_OUT[46])
        else $error("analog pin still driven");

    a_can_clock_pair: assert property (@(posedge I_CLK) disable iff (I_RST)
        O_CAN_AUX_CLOCK == {2{O_USB_PLL_REF_CLOCK}})
        else $error("aux clock copies disagree");

endmodule : dspm_pin_mux

/* verif/dspm_periph_model.sv */
`timescale 1ns/1ps
module dspm_periph_model
    import dspm_pkg::*;
(
    input  wire logic                                 i_phase,
    output dspm_pkg::dspm_mper_t [dspm_pkg::NPIN-1:0] o_m_periph,
    output dspm_pkg::dspm_cper_t [dspm_pkg::NPIN-1:0] o_c_periph
);
    // neighbouring slots carry opposite levels, so a pick one slot off shows at the pad
    always_comb
    begin
        for (int p = 0; p < NPIN; p++)
        begin
            for (int s = 0; s < MSLOT; s++)
                o_m_periph[p].o[s] = 1'((p + s) % 2) ^ i_phase;
            for (int s = 0; s < CSIG; s++)
                o_c_periph[p].o[s] = 1'((p + s) % 2) ^ i_phase;
            o_m_periph[p].oe = '1;
            o_c_periph[p].oe = '1;
        end
    end
endmodule : dspm_periph_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    import dspm_pkg::*;
    logic                                  I_CLK, I_RST, phase, wake, pll;
    logic [NPIN-1:0]                       pad_in, pu_en, pad_out, pad_oe, pad_pu, m_gpio, qual;
    dspm_mcfg_t [NMSET-1:0][MSET_PINS-1:0] m_cfg;
    dspm_ccfg_t [NCSET-1:0][CSET_PINS-1:0] c_cfg;
    dspm_mper_t [NPIN-1:0]                 m_per;
    dspm_cper_t [NPIN-1:0]                 c_per;
    logic [NROUTE-1:0][SELW-1:0]           rsel;
    logic [NPIN-1:0][MSLOT-1:0]            m_in;
    logic [NPIN-1:0][CSIG-1:0]             c_in;
    logic [NMSET-1:0]                      irq;
    logic [NTRIP-1:0]                      trip;
    logic [NCAP-1:0]                       cap;
    logic [NXINT-1:0]                      xint;
    logic [NLPM-1:0]                       lpm;
    logic [NUSB-1:0]                       amsel, usb_an;
    logic [1:0]                            can;
    int                                    error_cnt = 0, total_checks = 0, cycles = 0;

    dspm_periph_model i_model (.i_phase(phase), .o_m_periph(m_per), .o_c_periph(c_per));
    dspm_pin_mux i_dut (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_PAD_IN(pad_in), .I_M_CFG(m_cfg), .I_C_CFG(c_cfg),
        .I_PULLUP_EN(pu_en), .I_ANALOG_MODE_SELECT(amsel), .I_ROUTE_SEL(rsel),
        .I_M_PERIPH(m_per), .I_C_PERIPH(c_per), .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe),
        .O_PAD_PULLUP(pad_pu), .O_M_PERIPH_IN(m_in), .O_C_PERIPH_IN(c_in),
        .O_M_GPIO_IN(m_gpio), .O_M_IRQ(irq), .O_PIN_TRIP_EVENTS(trip), .O_CAPTURE_IN(cap),
        .O_CTRL_XINT(xint), .O_STANDBY_WAKE_SIGNAL(wake), .O_CONTROL_SIDE_PIN_INPUTS(lpm),
        .O_QUAL_PIN_INPUTS(qual), .O_USB_ANALOG_EN(usb_an), .O_USB_PLL_REF_CLOCK(pll),
        .O_CAN_AUX_CLOCK(can));

    task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // four edges covers the three-edge pad path with margin
    task automatic settle();
        repeat (4) @(posedge I_CLK);
        #1;
    endtask : settle

    function automatic logic pat(input int p, input int s);
        return 1'((p + s) % 2) ^ phase;
    endfunction : pat

    function automatic dspm_mcfg_t mc(input logic [3:0] f, input int a, oe, o, ie);
        return '{f, 1'(a), 1'(oe), 1'(o), 1'(ie)};
    endfunction : mc

    task automatic t_reset();
        @(posedge I_CLK);
        #1;
        check("pu_rst", 96'(pad_pu), 96'h0);
        check("oe_rst", 96'(pad_oe), 96'h0);
        @(posedge I_CLK);
        I_RST <= 1'h0;
        settle();
        check("gpio_master", 96'({pad_oe[5], pad_out[5]}), 96'h3);
        @(posedge I_CLK);
        pu_en <= {33{2'h2}};
        settle();
        check("pu_each", 96'(pad_pu), 96'({33{2'h2}}));
    endtask : t_reset

    task automatic t_master();
        for (int k = 0; k < MSLOT; k++)
        begin
            @(posedge I_CLK);
            phase <= 1'(k % 2);
            m_cfg[0][5] <= mc((k < MPRI) ? 4'(k + 1) : 4'(k - MPRI + 4), int'(k >= MPRI), 0, 0,
                              0);
            pad_in[5] <= 1'h1;
            settle();
            check("m_out", 96'({pad_oe[5], pad_out[5]}), 96'({1'h1, pat(5, k)}));
            check("m_in", 96'(m_in[5]), 96'(15'h1 << k));
        end
        @(posedge I_CLK);
        m_cfg[0][5] <= mc(4'hC, 0, 0, 0, 0);
        settle();
        check("m_none", 96'(pad_oe[5]), 96'h0);
    endtask : t_master

    task automatic t_control();
        for (int m = 0; m < CSIG; m++)
        begin
            @(posedge I_CLK);
            c_cfg[0][20] <= '{1'h1, 2'(m), 1'h0, 1'h0, 1'h0};
            // master side also asks for the pin, so a lost ownership shows in m_in
            m_cfg[2][4] <= mc(4'h1, 0, 1, 1, 0);
            pad_in[20] <= 1'h1;
            settle();
            check("c_out", 96'({pad_oe[20], pad_out[20]}), 96'({1'h1, pat(20, m)}));
            check("c_in", 96'({m_in[20], c_in[20]}), 96'(4'h1 << m));
        end
        @(posedge I_CLK);
        c_cfg[0][20] <= '{1'h1, 2'h0, 1'h1, 1'h1, 1'h1};
        settle();
        check("c_gpio", 96'({pad_oe[20], pad_out[20]}), 96'h3);
        @(posedge I_CLK);
        c_cfg[0][20] <= '{1'h1, 2'h0, 1'h1, 1'h0, 1'h1};
        settle();
        check("c_gpio_in", 96'(pad_oe[20]), 96'h0);
    endtask : t_control

    task automatic t_analog();
        @(posedge I_CLK);
        for (int i = 0; i < NUSB; i++)
        begin
            m_cfg[USB_PIN[i] / 8][USB_PIN[i] % 8] <= mc(4'h0, 0, 1, 1, 0);
            pad_in[USB_PIN[i]] <= 1'h1;
        end
        for (int a = 0; a < 3; a++)
        begin
            @(posedge I_CLK);
            amsel <= (a == 0) ? 4'hF : (a == 1) ? 4'h2 : 4'h0;
            settle();
            check("usb_en", 96'(usb_an), 96'(amsel));
            for (int i = 0; i < NUSB; i++)
            begin
                check("an_pin", 96'({pad_oe[USB_PIN[i]], qual[USB_PIN[i]], m_gpio[USB_PIN[i]]}),
                      96'({3{~amsel[i]}}));
            end
        end
    endtask : t_analog

    task automatic t_route();
        @(posedge I_CLK);
        for (int r = 0; r < NROUTE; r++)
            rsel[r] <= 6'(r);
        pad_in[21:0] <= 22'h2AAAAA;
        settle();
        check("routes", 96'({wake, xint, cap, trip}), 96'h2AAAAA);
        check("lpm_qual", 96'({lpm[21:0], qual[21:0]}), 96'({2{22'h2AAAAA}}));
        for (int b = 0; b < 2; b++)
        begin
            @(posedge I_CLK);
            for (int r = 0; r < NROUTE; r++)
                rsel[r] <= b ? 6'h2C : 6'h27;
            pad_in[39] <= 1'h1;
            pad_in[44] <= 1'h1;
            settle();
            check("barred", 96'({wake, xint, cap, trip}), 96'h0);
            check("qual_barred", 96'({qual[44], qual[39]}), 96'h3);
        end
    endtask : t_route

    task automatic t_irq_clk();
        @(posedge I_CLK);
        m_cfg[2][1] <= mc(4'h0, 0, 0, 0, 1);
        m_cfg[8][1] <= mc(4'h0, 0, 0, 0, 1);
        pad_in[65:63] <= 3'h7;
        pad_in[17] <= 1'h1;
        settle();
        check("irq", 96'(irq), 96'h104);
        check("aux_clk", 96'({can, pll, lpm[63]}), 96'hF);
        check("qual_top", 96'(qual[65:64]), 96'h3);
        @(posedge I_CLK);
        pad_in[63] <= 1'h0;
        pad_in[17] <= 1'h0;
        settle();
        check("aux_low", 96'({can, pll}), 96'h0);
        check("irq_8", 96'(irq), 96'h100);
    endtask : t_irq_clk

    initial
    begin
        I_CLK = 1'h0;
        forever #2.5 I_CLK = ~I_CLK;
    end

    // a hang would otherwise never reach the verdict
    always @(posedge I_CLK)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    initial
    begin
        I_RST = 1'h1;
        phase = 1'h0;
        pad_in = '0;
        pu_en = '1;
        m_cfg = '0;
        c_cfg = '0;
        amsel = '0;
        rsel = '0;
        m_cfg[0][5] = mc(4'h0, 0, 1, 1, 0);
        t_reset();
        t_master();
        t_control();
        t_analog();
        t_route();
        t_irq_clk();
        print_verdict();
    end
endmodule : tb
